// [design/completion_stream_adapter.sv]
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module completion_stream_adapter #(
	parameter int DATA_W = 256
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic resetn_i,
	// Register port.
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	output logic irq_o,
	// Core side of the requester completion stream.
	input wire logic core_valid_i,
	output logic core_ready_o,
	input wire logic [DATA_W-1:0] core_data_i,
	input wire logic [DATA_W/8-1:0] core_byte_en_i,
	input wire logic core_first_start_i,
	input wire logic [3:0] core_first_end_i,
	input wire logic core_second_start_i,
	input wire logic [3:0] core_second_end_i,
	input wire logic core_discontinue_i,
	input wire logic core_last_i,
	// Requester completion stream to user logic.
	output logic rc_valid_o,
	input wire logic rc_ready_i,
	output logic [DATA_W-1:0] rc_data_o,
	output logic [cpl_stream_pkg::RC_USER_W-1:0] req_completion_sideband_o,
	output logic [DATA_W/32-1:0] req_completion_word_keep_o,
	output logic rc_last_o,
	// Served completion stream from user logic.
	input wire logic cc_valid_i,
	output logic cc_ready_o,
	input wire logic [DATA_W-1:0] served_completion_payload_i,
	input wire logic [cpl_stream_pkg::CC_USER_W-1:0] served_completion_sideband_i,
	input wire logic [DATA_W/32-1:0] served_completion_word_keep_i,
	input wire logic cc_last_i,
	input wire logic core_cc_ready_i,
	output logic straddle_active_o
);
	localparam int WORDS = DATA_W / cpl_stream_pkg::WORD_BITS;
	localparam int WORD_BYTES = cpl_stream_pkg::WORD_BITS / 8;
	localparam bit STRADDLE_OK = (DATA_W == cpl_stream_pkg::STRADDLE_WIDTH);

	////////////////////////////////////////////////////////////////////////
	// Registers.
	logic ctrl_straddle;
	logic [cpl_stream_pkg::EV_W-1:0] status;
	logic [cpl_stream_pkg::EV_W-1:0] mask;
	logic [15:0] cc_done_count;
	logic next_ctrl_straddle;
	logic [cpl_stream_pkg::EV_W-1:0] next_status;
	logic [cpl_stream_pkg::EV_W-1:0] next_mask;
	logic [15:0] next_cc_done_count;
	logic [31:0] next_rdata;
	logic [cpl_stream_pkg::EV_W-1:0] ev;
	cpl_stream_pkg::cc_event_t cc_ev;
	logic [cpl_stream_pkg::DESC_BCNT_W-1:0] cc_bcnt;

	// The straddle enable cannot take effect on narrower streams.
	assign straddle_active_o = ctrl_straddle & STRADDLE_OK;

	always_comb begin
		next_ctrl_straddle = ctrl_straddle;
		next_mask = mask;
		next_status = status;
		next_cc_done_count = cc_done_count + {15'h0, cc_ev.done};
		next_rdata = '0;
		if (reg_wr_i) begin
			case (reg_addr_i)
				cpl_stream_pkg::REG_CTRL: next_ctrl_straddle = reg_wdata_i[cpl_stream_pkg::CTRL_STRADDLE];
				cpl_stream_pkg::REG_STATUS: next_status = status & ~reg_wdata_i[cpl_stream_pkg::EV_W-1:0];
				cpl_stream_pkg::REG_MASK: next_mask = reg_wdata_i[cpl_stream_pkg::EV_W-1:0];
				default: ;
			endcase
		end
		// Setting after clearing lets an event win over a simultaneous clear.
		next_status = next_status | ev;
		if (reg_rd_i) begin
			case (reg_addr_i)
				cpl_stream_pkg::REG_CTRL: next_rdata = {31'h0, straddle_active_o};
				cpl_stream_pkg::REG_STATUS: next_rdata = {28'h0, status};
				cpl_stream_pkg::REG_MASK: next_rdata = {28'h0, mask};
				cpl_stream_pkg::REG_COUNT: next_rdata = {3'h0, cc_bcnt, cc_done_count};
				default: next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ctrl_straddle <= 1'b0;
			status <= '0;
			mask <= '0;
			cc_done_count <= '0;
			reg_rdata_o <= '0;
		end else begin
			ctrl_straddle <= next_ctrl_straddle;
			status <= next_status;
			mask <= next_mask;
			cc_done_count <= next_cc_done_count;
			reg_rdata_o <= next_rdata;
		end
	end

	assign irq_o = |(status & mask);

	////////////////////////////////////////////////////////////////////////
	// Requester completion output stage.
	logic rc_take;
	logic [cpl_stream_pkg::RC_USER_W-1:0] next_sideband;
	logic [WORDS-1:0] next_keep;
	logic rc_poison_seen;
	logic [cpl_stream_pkg::RC_PAR_W-1:0] next_parity;

	assign core_ready_o = !rc_valid_o || rc_ready_i;
	assign rc_take = core_valid_i && core_ready_o;

	genvar gw;
	generate
		for (gw = 0; gw < WORDS; gw++) begin : g_word
			// One keep bit per word, set when any byte of it is enabled.
			assign next_keep[gw] = |core_byte_en_i[gw*WORD_BYTES +: WORD_BYTES];
			assign next_parity[gw] = ~^core_data_i[gw*cpl_stream_pkg::WORD_BITS +: cpl_stream_pkg::WORD_BITS];
		end
		// Parity bits beyond the stream's word count read as zero.
		if (WORDS < cpl_stream_pkg::RC_PAR_W) begin : g_par_pad
			assign next_parity[cpl_stream_pkg::RC_PAR_W-1:WORDS] = '0;
		end
	endgenerate

	always_comb begin
		next_sideband = '0;
		next_sideband[cpl_stream_pkg::RC_PAR_LO +: cpl_stream_pkg::RC_PAR_W] = next_parity;
		next_sideband[cpl_stream_pkg::RC_BE_LO +: DATA_W/8] = core_byte_en_i;
		next_sideband[cpl_stream_pkg::RC_SOF0_BIT] = core_first_start_i;
		next_sideband[cpl_stream_pkg::RC_EOF0_LO +: cpl_stream_pkg::RC_EOF_W] = core_first_end_i;
		if (straddle_active_o) begin
			next_sideband[cpl_stream_pkg::RC_SOF1_BIT] = core_second_start_i;
			next_sideband[cpl_stream_pkg::RC_EOF1_LO +: cpl_stream_pkg::RC_EOF_W] = core_second_end_i;
		end
		// Left at zero otherwise, so stale values cannot mislead the user.
		next_sideband[cpl_stream_pkg::RC_DISC_BIT] = core_discontinue_i;
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rc_valid_o <= 1'b0;
			rc_data_o <= '0;
			req_completion_sideband_o <= '0;
			req_completion_word_keep_o <= '0;
			rc_last_o <= 1'b0;
		end else begin
			if (core_ready_o)
				rc_valid_o <= core_valid_i;
			if (rc_take) begin
				rc_data_o <= core_data_i;
				req_completion_sideband_o <= next_sideband;
				req_completion_word_keep_o <= next_keep;
				rc_last_o <= core_last_i;
			end
		end
	end

	// Poison is only examined on a beat that opens a completion.
	assign rc_poison_seen = rc_valid_o && rc_ready_i &&
		(req_completion_sideband_o[cpl_stream_pkg::RC_SOF0_BIT] ||
		req_completion_sideband_o[cpl_stream_pkg::RC_SOF1_BIT]) &&
		rc_data_o[cpl_stream_pkg::DESC_POISON_BIT];

	////////////////////////////////////////////////////////////////////////
	// Served completion observation.
	assign cc_ready_o = core_cc_ready_i;

	cc_tracker #(.DATA_W(DATA_W)) u_cc (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.beat_i(cc_valid_i && cc_ready_o),
		.last_i(cc_last_i),
		.data_i(served_completion_payload_i),
		.user_i(served_completion_sideband_i),
		.event_o(cc_ev),
		.byte_count_o(cc_bcnt)
	);

	always_comb begin
		ev = '0;
		ev[cpl_stream_pkg::EV_CC_POISON] = cc_ev.poison;
		ev[cpl_stream_pkg::EV_CC_ECRC] = cc_ev.ecrc;
		ev[cpl_stream_pkg::EV_CC_ABORT] = cc_ev.abort;
		ev[cpl_stream_pkg::EV_RC_POISON] = rc_poison_seen;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.
	a_rc_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
		rc_valid_o && !rc_ready_i |=> rc_valid_o && $stable(rc_data_o) && $stable(rc_last_o)
		&& $stable(req_completion_sideband_o))
		else $error("Completion beat changed while stalled.");
	a_second_quiet: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!$past(straddle_active_o) && $past(rc_take) |-> !req_completion_sideband_o[cpl_stream_pkg::RC_SOF1_BIT])
		else $error("Second start flagged without straddling.");
	a_first_start: assert property (@(posedge clk_i) disable iff (!resetn_i)
		rc_take |=> req_completion_sideband_o[cpl_stream_pkg::RC_SOF0_BIT] == $past(core_first_start_i)
		&& req_completion_sideband_o[cpl_stream_pkg::RC_EOF0_LO +: cpl_stream_pkg::RC_EOF_W] == $past(core_first_end_i))
		else $error("First start or end position mismatch.");
	a_byte_en: assert property (@(posedge clk_i) disable iff (!resetn_i)
		rc_take |=> req_completion_sideband_o[DATA_W/8-1:0] == $past(core_byte_en_i)
		&& req_completion_word_keep_o == $past(next_keep))
		else $error("Byte enables not forwarded.");
	a_second_fields: assert property (@(posedge clk_i) disable iff (!resetn_i)
		rc_take && straddle_active_o |=>
		req_completion_sideband_o[cpl_stream_pkg::RC_EOF1_LO +: cpl_stream_pkg::RC_EOF_W] == $past(core_second_end_i))
		else $error("Second end position mismatch.");
	a_straddle_width: assert property (@(posedge clk_i) disable iff (!resetn_i)
		straddle_active_o |-> DATA_W == cpl_stream_pkg::STRADDLE_WIDTH)
		else $error("Straddling on a narrow stream.");
	a_poison_event: assert property (@(posedge clk_i) disable iff (!resetn_i)
		rc_poison_seen |=> status[cpl_stream_pkg::EV_RC_POISON])
		else $error("Poisoned completion not recorded.");
	a_abort_event: assert property (@(posedge clk_i) disable iff (!resetn_i)
		cc_valid_i && cc_ready_o && served_completion_sideband_i[cpl_stream_pkg::CC_DISC_BIT]
		|=> ##1 status[cpl_stream_pkg::EV_CC_ABORT])
		else $error("Discontinue not recorded.");
	c_straddle: cover property (@(posedge clk_i) rc_take && straddle_active_o && core_second_start_i);
	c_stall: cover property (@(posedge clk_i) rc_valid_o && !rc_ready_i ##1 rc_valid_o && rc_ready_i);
	c_cc_done: cover property (@(posedge clk_i) cc_valid_i && cc_ready_o && cc_last_i);
endmodule

// [design/cpl_stream_pkg.sv]
package cpl_stream_pkg;

	// Requester completion sideband layout.
	localparam int RC_USER_W = 75;
	localparam int RC_BE_LO = 0;
	localparam int RC_BE_W = 32;
	localparam int RC_SOF0_BIT = 32;
	localparam int RC_SOF1_BIT = 33;
	localparam int RC_EOF0_LO = 34;
	localparam int RC_EOF1_LO = 38;
	localparam int RC_EOF_W = 4;
	localparam int RC_DISC_BIT = 42;
	localparam int RC_PAR_LO = 43;
	localparam int RC_PAR_W = 32;

	// Completion descriptor fields.
	localparam int DESC_POISON_BIT = 46;
	localparam int DESC_BCNT_LO = 16;
	localparam int DESC_BCNT_W = 13;
	localparam int DESC_ECRC_BIT = 95;

	// Served completion sideband layout.
	localparam int CC_USER_W = 33;
	localparam int CC_DISC_BIT = 0;

	localparam int STRADDLE_WIDTH = 256;
	localparam int WORD_BITS = 32;

	// Register offsets.
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_MASK = 4'h8;
	localparam logic [3:0] REG_COUNT = 4'hC;

	// Control bits and event bits.
	localparam int CTRL_STRADDLE = 0;
	localparam int EV_W = 4;
	localparam int EV_CC_POISON = 0;
	localparam int EV_CC_ECRC = 1;
	localparam int EV_CC_ABORT = 2;
	localparam int EV_RC_POISON = 3;

	typedef struct packed {
		logic poison;
		logic ecrc;
		logic abort;
		logic done;
	} cc_event_t;

	typedef enum logic [1:0] {
		CC_IDLE = 2'b00,
		CC_BODY = 2'b01
	} cc_state_t;

endpackage

// [design/cc_tracker.sv]
`timescale 1ns/1ps
// Follows the served completion stream and reports descriptor flags.
module cc_tracker #(
	parameter int DATA_W = 256
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic resetn_i,
	// Observed beat.
	input wire logic beat_i,
	input wire logic last_i,
	input wire logic [DATA_W-1:0] data_i,
	input wire logic [cpl_stream_pkg::CC_USER_W-1:0] user_i,
	// Results.
	output cpl_stream_pkg::cc_event_t event_o,
	output logic [cpl_stream_pkg::DESC_BCNT_W-1:0] byte_count_o
);
	cpl_stream_pkg::cc_state_t state;
	cpl_stream_pkg::cc_state_t next_state;
	cpl_stream_pkg::cc_event_t next_event;
	logic [cpl_stream_pkg::DESC_BCNT_W-1:0] next_byte_count;

	always_comb begin
		next_state = state;
		next_event = '0;
		next_byte_count = byte_count_o;
		if (beat_i) begin
			// The descriptor is present only on the first beat of a completion.
			if (state == cpl_stream_pkg::CC_IDLE) begin
				next_event.poison = data_i[cpl_stream_pkg::DESC_POISON_BIT];
				next_event.ecrc = data_i[cpl_stream_pkg::DESC_ECRC_BIT];
				next_byte_count = data_i[cpl_stream_pkg::DESC_BCNT_LO +: cpl_stream_pkg::DESC_BCNT_W];
			end
			next_event.abort = user_i[cpl_stream_pkg::CC_DISC_BIT];
			next_event.done = last_i;
			case (state)
				cpl_stream_pkg::CC_IDLE: begin
					next_state = last_i ? cpl_stream_pkg::CC_IDLE : cpl_stream_pkg::CC_BODY;
				end
				cpl_stream_pkg::CC_BODY: begin
					if (last_i)
						next_state = cpl_stream_pkg::CC_IDLE;
				end
				default: begin
					next_state = cpl_stream_pkg::CC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			state <= cpl_stream_pkg::CC_IDLE;
			event_o <= '0;
			byte_count_o <= '0;
		end else begin
			state <= next_state;
			event_o <= next_event;
			byte_count_o <= next_byte_count;
		end
	end
endmodule

// [tb/user_side.sv]
`timescale 1ns/1ps
// Stands in for user logic: consumes requester completions and sources served ones.
module user_side (
	// Clock and control.
	input wire logic clk_i,
	input wire logic stall_i,
	// Requester completion stream.
	output logic rc_ready_o,
	// Served completion stream.
	input wire logic cc_ready_i,
	output logic cc_valid_o,
	output logic [255:0] cc_data_o,
	output logic [32:0] cc_user_o,
	output logic [7:0] cc_keep_o,
	output logic cc_last_o
);
	assign rc_ready_o = !stall_i;
	initial begin
		{cc_valid_o, cc_data_o, cc_user_o, cc_keep_o, cc_last_o} = '0;
	end
	// Released lines show the inverse so that stale content never passes for a beat.
	task automatic send(input logic [255:0] d, input logic [32:0] u, input logic [7:0] k, input logic l);
		@(posedge clk_i);
		{cc_valid_o, cc_data_o, cc_user_o, cc_keep_o, cc_last_o} <= {1'b1, d, u, k, l};
		do @(posedge clk_i); while (cc_ready_i !== 1'b1);
		{cc_valid_o, cc_data_o, cc_user_o, cc_keep_o, cc_last_o} <= {1'b0, ~{d, u, k, l}};
	endtask
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
	localparam logic [255:0] D = {32'h1, 32'h3, 32'h7, 32'hF, 32'h1F, 32'h3F, 32'h7F, 32'hFF};
	logic clk_i, resetn_i, reg_wr_i, reg_rd_i, irq_o, stall, stra, rc_ready_i;
	logic [3:0] reg_addr_i, e0, e1;
	logic [31:0] reg_wdata_i, reg_rdata_o, rd_val, be;
	logic core_valid_i, core_ready_o, s0, s1, rc_valid_o, rc_last_o, core_last_i;
	logic [255:0] core_data_i, rc_data_o, cc_data;
	logic [74:0] rc_sb, exp_sb;
	logic [7:0] rc_keep, exp_keep, cc_keep;
	logic cc_valid, cc_ready_o, cc_last, straddle_active_o, core_rdy;
	logic [32:0] cc_user;
	int err_count = 0;
	int checks = 0;

	completion_stream_adapter #(.DATA_W(256)) dut_u (.clk_i(clk_i), .resetn_i(resetn_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .core_valid_i(core_valid_i), .core_ready_o(core_ready_o),
		.core_data_i(core_data_i), .core_byte_en_i(be), .core_first_start_i(s0), .core_first_end_i(e0),
		.core_second_start_i(s1), .core_second_end_i(e1), .core_discontinue_i(1'b0), .core_last_i(core_last_i),
		.rc_valid_o(rc_valid_o), .rc_ready_i(rc_ready_i), .rc_data_o(rc_data_o),
		.req_completion_sideband_o(rc_sb), .req_completion_word_keep_o(rc_keep), .rc_last_o(rc_last_o),
		.cc_valid_i(cc_valid), .cc_ready_o(cc_ready_o), .served_completion_payload_i(cc_data),
		.served_completion_sideband_i(cc_user), .served_completion_word_keep_i(cc_keep), .cc_last_i(cc_last),
		.core_cc_ready_i(core_rdy), .straddle_active_o(straddle_active_o));
	user_side usr_u (.clk_i(clk_i), .stall_i(stall), .rc_ready_o(rc_ready_i), .cc_ready_i(cc_ready_o),
		.cc_valid_o(cc_valid), .cc_data_o(cc_data), .cc_user_o(cc_user), .cc_keep_o(cc_keep), .cc_last_o(cc_last));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [255:0] seen, input logic [255:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk_i);
		{reg_rd_i, reg_addr_i} <= {1'b1, a};
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 rd_val = reg_rdata_o;
	endtask
	// Offers one beat and checks what reaches user logic right after the take.
	task automatic rc_beat(input logic [255:0] d, input logic [31:0] b, input logic a0, input logic [3:0] f0,
		input logic a1, input logic [3:0] f1);
		logic r;
		logic [31:0] par;
		par = '0;
		@(posedge clk_i);
		{core_valid_i, core_data_i, be, s0, e0, s1, e1, core_last_i} <= {1'b1, d, b, a0, f0, a1, f1, 1'b1};
		do begin
			@(negedge clk_i) r = core_ready_o;
			@(posedge clk_i);
		end while (!r);
		core_valid_i <= 1'b0;
		for (int w = 0; w < 8; w++) begin
			par[w] = ~^d[32*w+:32];
			exp_keep[w] = |b[4*w+:4];
		end
		exp_sb = {par, 1'b0, stra ? f1 : 4'h0, f0, stra & a1, a0, b};
		#1 chk("rc sideband", rc_sb, exp_sb);
		chk("rc keep", rc_keep, exp_keep);
		chk("rc data", rc_data_o, d);
		chk("rc valid last", {rc_valid_o, rc_last_o}, 2'b11);
	endtask

	task automatic t_regs();
		logic [3:0] addr [5];
		addr = '{cpl_stream_pkg::REG_CTRL, cpl_stream_pkg::REG_STATUS, cpl_stream_pkg::REG_MASK,
			cpl_stream_pkg::REG_COUNT, 4'h2};
		wr(4'h2, 32'hFFFF_FFFF);
		foreach (addr[i]) begin
			rd(addr[i]);
			chk("reset register", rd_val, 32'h0);
		end
		$display("test regs done");
	endtask
	task automatic t_rc();
		stall <= 1'b1;
		rc_beat(D, 32'h0000_F0F1, 1'b1, 4'h7, 1'b1, 4'h5);
		repeat (3) @(posedge clk_i);
		#1 chk("held beat", {rc_valid_o, core_ready_o, rc_sb}, {2'b10, exp_sb});
		@(posedge clk_i);
		stall <= 1'b0;
		wr(cpl_stream_pkg::REG_CTRL, 32'h1);
		stra = 1'b1;
		rd(cpl_stream_pkg::REG_CTRL);
		chk("straddle enable", {rd_val, straddle_active_o}, {32'h1, 1'b1});
		// The descriptor poison bit is kept clear so that the status is still empty for the poison test.
		rc_beat(~D ^ (256'h1 << cpl_stream_pkg::DESC_POISON_BIT), 32'hFFFF_000F, 1'b1, 4'h3, 1'b1, 4'h9);
		$display("test rc done");
	endtask
	task automatic t_poison();
		rc_beat(D | (256'h1 << 46), 32'hFF, 1'b0, 4'h1, 1'b0, 4'h0);
		rd(cpl_stream_pkg::REG_STATUS);
		chk("poison without start", rd_val, 32'h0);
		rc_beat(D | (256'h1 << 46), 32'hFF, 1'b1, 4'h1, 1'b0, 4'h0);
		rd(cpl_stream_pkg::REG_STATUS);
		chk("poison with start", {rd_val, irq_o}, {32'h8, 1'b0});
		wr(cpl_stream_pkg::REG_MASK, 32'h8);
		chk("irq unmasked", irq_o, 1'b1);
		wr(cpl_stream_pkg::REG_STATUS, 32'h8);
		rd(cpl_stream_pkg::REG_STATUS);
		chk("status cleared", {rd_val, irq_o}, {32'h0, 1'b0});
		$display("test poison done");
	endtask
	task automatic t_cc();
		@(posedge clk_i);
		core_rdy <= 1'b0;
		// The core holds off the first beat for a while; the user side must keep it offered.
		fork
			usr_u.send((256'h1 << 95) | (256'h1 << 46) | (256'h45 << 16), 33'h0, 8'hFF, 1'b0);
			begin
				@(posedge clk_i);
				#1 chk("cc ready low", cc_ready_o, 1'b0);
				@(posedge clk_i);
				core_rdy <= 1'b1;
			end
		join
		#1 chk("cc ready high", cc_ready_o, 1'b1);
		usr_u.send(D, 33'h0, 8'h03, 1'b1);
		repeat (3) @(posedge clk_i);
		rd(cpl_stream_pkg::REG_COUNT);
		chk("count", rd_val, {3'h0, 13'h045, 16'h1});
		rd(cpl_stream_pkg::REG_STATUS);
		chk("cc flags", rd_val, 32'h3);
		usr_u.send(D, 33'h1, 8'hFF, 1'b1);
		repeat (3) @(posedge clk_i);
		rd(cpl_stream_pkg::REG_STATUS);
		chk("cc abort", {rd_val, irq_o}, {32'h7, 1'b0});
		$display("test cc done");
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	initial begin
		#100000;
		err_count++;
		finish_test();
	end
	initial begin
		{reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, core_valid_i, core_data_i, be} = '0;
		{s0, e0, s1, e1, core_last_i, stall, stra, resetn_i} = '0;
		core_rdy = 1'b1;
		repeat (2) @(posedge clk_i);
		resetn_i <= 1'b1;
		t_regs();
		t_rc();
		t_poison();
		t_cc();
		finish_test();
	end
endmodule
